//--- logic/adm_pkg.sv
// Package for the converter diagnostic monitor: register map, flag layout,
// enable-word layout and counting constants.
// Assumes a 32-bit APB host and a single master clock pclk.
package adm_pkg;

   // Register byte offsets
   localparam logic [7:0] ADM_OFS_ENABLE = 8'h00; // Diagnostic enables
   localparam logic [7:0] ADM_OFS_ERROR = 8'h04; // Latched flags, clear on read
   localparam logic [7:0] ADM_OFS_STATUS = 8'h08; // Summary error bit
   localparam logic [7:0] ADM_OFS_TALLY = 8'h0C; // Master-clock tally
   localparam logic [7:0] ADM_OFS_OFFSET = 8'h10; // Offset coefficient
   localparam logic [7:0] ADM_OFS_GAIN = 8'h14; // Gain coefficient
   localparam logic [7:0] ADM_OFS_DATA = 8'h18; // Conversion result

   // Flag positions in the error register
   localparam int ADM_E_CAL = 0;
   localparam int ADM_E_CONV = 1;
   localparam int ADM_E_SAT = 2;
   localparam int ADM_E_PHI = 3;
   localparam int ADM_E_PLO = 4;
   localparam int ADM_E_NHI = 5;
   localparam int ADM_E_NLO = 6;
   localparam int ADM_E_ADR = 7;
   localparam int ADM_E_DDR = 8;
   localparam int ADM_E_CAP = 9;
   localparam int ADM_E_SCK = 10;
   localparam int ADM_ERR_W = 11;

   // Widths and counts
   localparam int ADM_DATA_W = 24;
   localparam int ADM_TALLY_W = 8;
   localparam logic [7:0] ADM_TALLY_DIV = 8'h83; // 131 master clocks per step
   localparam logic [4:0] ADM_STUCK_RUN = 5'h14; // 20 equal modulator bits
   localparam logic [23:0] ADM_OFS_MIN = 24'h07_FFFF;
   localparam logic [23:0] ADM_OFS_MAX = 24'hF8_0000;
   localparam logic [1:0] ADM_CAP_NONE = 2'h0;
   localparam logic [1:0] ADM_CAP_ANALOG = 2'h1;
   localparam logic [1:0] ADM_CAP_DIGITAL = 2'h2;
   localparam logic [15:0] ADM_EN_RESET = 16'h0000; // All checks off
   localparam int ADM_SYNC_W = 10; // Pins passed through synchronisers
   localparam logic [9:0] ADM_SYNC_RST = 10'h100; // Select idles high, no false frame

   // Enable word, bit 0 at the bottom
   typedef struct packed {
      logic serial_pulse_count_enable; // 15
      logic osc_tally_enable; // 14
      logic decoupling_check_selftest; // 13
      logic [1:0] decoupling_check_select; // 12:11
      logic digital_droop_selftest; // 10
      logic analog_droop_selftest; // 9
      logic digital_rail_droop_enable; // 8
      logic analog_rail_droop_enable; // 7
      logic neg_input_low_enable; // 6
      logic neg_input_high_enable; // 5
      logic pos_input_low_enable; // 4
      logic pos_input_high_enable; // 3
      logic modulator_stuck_enable; // 2
      logic filter_range_fault_enable; // 1
      logic calibration_fault_enable; // 0
   } adm_en_s;

   // Serial frame tracker
   typedef enum logic [0:0] {
      ADM_FR_IDLE = 1'b0,
      ADM_FR_BUSY = 1'b1
   } adm_frame_e;

endpackage

//--- logic/adm_monitor.sv
// Diagnostic monitor for a sigma-delta converter: latched fault flags,
// master-clock tally, serial clock pulse counting, APB register access.
// Assumes filter/modulator/calibration strobes come from pclk logic;
// comparators and serial pins are asynchronous and are synchronised here.
module adm_monitor
   import adm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Digital filter, pclk domain
   input wire logic conv_done,
   input wire logic conv_overflow,
   input wire logic conv_underflow,
   input wire logic [ADM_DATA_W-1:0] conv_raw,
   output logic [ADM_DATA_W-1:0] conv_result,
   output logic conv_result_valid,
   // Modulator bitstream, pclk domain
   input wire logic mod_bit_valid,
   input wire logic mod_bit,
   // Calibration engine, pclk domain
   input wire logic cal_done,
   input wire logic cal_is_gain,
   input wire logic cal_overflow,
   input wire logic [ADM_DATA_W-1:0] cal_coeff,
   output logic [ADM_DATA_W-1:0] offset_coeff,
   output logic [ADM_DATA_W-1:0] gain_coeff,
   // Analog comparators, asynchronous
   input wire logic pos_input_high,
   input wire logic pos_input_low,
   input wire logic neg_input_high,
   input wire logic neg_input_low,
   input wire logic analog_rail_low,
   input wire logic digital_rail_low,
   input wire logic decoupling_falling,
   // LDO test controls to the analog side
   output logic analog_droop_gnd,
   output logic digital_droop_gnd,
   output logic analog_ldo_off,
   output logic digital_ldo_off,
   output logic decoupling_disconnect,
   // Serial port pins, asynchronous; write commit and abort, pclk domain
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic spi_is_write,
   output logic spi_write_commit,
   output logic spi_write_abort
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   adm_en_s en_r; // Enable register
   logic [ADM_ERR_W-1:0] err_r; // Latched flags
   logic [ADM_ERR_W-1:0] err_set; // Per-flag set this cycle
   logic [ADM_ERR_W-1:0] err_clr; // Per-flag clear mask
   logic summary_r; // Status summary bit
   logic [ADM_TALLY_W-1:0] tally_r; // Master-clock tally
   logic [7:0] presc_r; // Divide-by-131 prescaler
   logic [4:0] run_r; // Equal-bit run length
   logic last_bit_r; // Previous modulator bit
   logic [ADM_SYNC_W-1:0] sync1_r; // First synchroniser stage
   logic [ADM_SYNC_W-1:0] sync2_r; // Second synchroniser stage
   logic sclk_d_r; // Delayed synchronised sclk
   adm_frame_e frame_r; // Frame state
   logic [2:0] pulse_r; // Pulse count modulo eight
   logic frame_end; // Chip select released
   logic bad_count; // Frame length not a multiple of eight
   logic offset_ok; // Offset inside window
   logic [ADM_ERR_W-1:0] rd_snap_r; // Flags as returned to host
   logic apb_done; // Transfer completes this edge
   logic [31:0] rd_mux; // Read data selection
   logic rd_hit; // Address is mapped
   logic s_phi, s_plo, s_nhi, s_nlo, s_adr, s_ddr, s_cap, s_sck, s_cs_n, s_wr;

   assign {s_wr, s_cs_n, s_sck, s_cap, s_ddr, s_adr, s_nlo, s_nhi, s_plo, s_phi} = sync2_r;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; stage one feeds only stage two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= ADM_SYNC_RST;
         sync2_r <= ADM_SYNC_RST;
      end else begin
         sync1_r <= {spi_is_write, cs_n, sclk, decoupling_falling, digital_rail_low,
                     analog_rail_low, neg_input_low, neg_input_high, pos_input_low,
                     pos_input_high};
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, pready from a flop
   assign apb_done = psel & penable & pready;

   // Read mux, zero for unmapped addresses
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr[7:0])
         ADM_OFS_ENABLE: rd_mux = {16'h0000, en_r};
         ADM_OFS_ERROR: rd_mux = {21'h00_0000, err_r};
         ADM_OFS_STATUS: rd_mux = {31'h0000_0000, summary_r};
         ADM_OFS_TALLY: rd_mux = {24'h00_0000, tally_r};
         ADM_OFS_OFFSET: rd_mux = {8'h00, offset_coeff};
         ADM_OFS_GAIN: rd_mux = {8'h00, gain_coeff};
         ADM_OFS_DATA: rd_mux = {8'h00, conv_result};
         default: rd_hit = 1'b0;
      endcase
      if (paddr[31:8] != 24'h00_0000) begin
         rd_hit = 1'b0;
         rd_mux = 32'h0000_0000;
      end
   end

   // Answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         rd_snap_r <= '0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
            // Only the flags actually returned are cleared later
            rd_snap_r <= (!pwrite && paddr == 32'(ADM_OFS_ERROR)) ? err_r : '0;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Enable register, written at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= adm_en_s'(ADM_EN_RESET);
      end else if (apb_done && pwrite && paddr == 32'(ADM_OFS_ENABLE)) begin
         en_r <= adm_en_s'(pwdata[15:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion result with clamping on filter range faults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_result <= '0;
         conv_result_valid <= 1'b0;
      end else begin
         conv_result_valid <= conv_done;
         if (conv_done) begin
            if (conv_overflow) begin
               conv_result <= '1;
            end else if (conv_underflow) begin
               conv_result <= '0;
            end else begin
               conv_result <= conv_raw;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Modulator run length; saturates at the threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 5'h00;
         last_bit_r <= 1'b0;
      end else if (mod_bit_valid) begin
         last_bit_r <= mod_bit;
         if (run_r != 5'h00 && mod_bit == last_bit_r) begin
            if (run_r != ADM_STUCK_RUN) begin
               run_r <= run_r + 5'h01;
            end
         end else begin
            run_r <= 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration coefficients; bad results leave them untouched
   assign offset_ok = (cal_coeff >= ADM_OFS_MIN) && (cal_coeff <= ADM_OFS_MAX);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_coeff <= '0;
         gain_coeff <= '0;
      end else if (cal_done) begin
         if (!cal_is_gain && offset_ok) begin
            offset_coeff <= cal_coeff;
         end
         if (cal_is_gain && !cal_overflow) begin
            gain_coeff <= cal_coeff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tally: prescaler of 131 then a wrapping counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= 8'h00;
         tally_r <= '0;
      end else if (en_r.osc_tally_enable) begin
         if (presc_r == ADM_TALLY_DIV - 8'h01) begin
            presc_r <= 8'h00;
            tally_r <= tally_r + 1'b1;
         end else begin
            presc_r <= presc_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial frame tracker; counts synchronised sclk rising edges
   assign frame_end = (frame_r == ADM_FR_BUSY) && s_cs_n;
   assign bad_count = pulse_r != 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_r <= ADM_FR_IDLE;
         pulse_r <= 3'h0;
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= s_sck;
         case (frame_r)
            ADM_FR_IDLE: begin
               pulse_r <= 3'h0;
               if (!s_cs_n) begin
                  frame_r <= ADM_FR_BUSY;
               end
            end
            ADM_FR_BUSY: begin
               if (s_cs_n) begin
                  frame_r <= ADM_FR_IDLE;
               end else if (s_sck && !sclk_d_r) begin
                  pulse_r <= pulse_r + 3'h1;
               end
            end
            default: frame_r <= ADM_FR_IDLE;
         endcase
      end
   end

   // Write commit or abort at end of a write frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spi_write_commit <= 1'b0;
         spi_write_abort <= 1'b0;
      end else begin
         spi_write_commit <= frame_end & s_wr & ~(en_r.serial_pulse_count_enable & bad_count);
         spi_write_abort <= frame_end & s_wr & en_r.serial_pulse_count_enable & bad_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // LDO test controls to the analog side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_droop_gnd <= 1'b0;
         digital_droop_gnd <= 1'b0;
         analog_ldo_off <= 1'b0;
         digital_ldo_off <= 1'b0;
         decoupling_disconnect <= 1'b0;
      end else begin
         analog_droop_gnd <= en_r.analog_droop_selftest;
         digital_droop_gnd <= en_r.digital_droop_selftest;
         analog_ldo_off <= en_r.decoupling_check_select == ADM_CAP_ANALOG;
         digital_ldo_off <= en_r.decoupling_check_select == ADM_CAP_DIGITAL;
         decoupling_disconnect <= en_r.decoupling_check_selftest;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag set terms; a set always beats a clear in the same cycle
   always_comb begin
      err_set = '0;
      err_set[ADM_E_CAL] = en_r.calibration_fault_enable & cal_done &
                           (cal_is_gain ? cal_overflow : ~offset_ok);
      err_set[ADM_E_CONV] = en_r.filter_range_fault_enable & conv_done &
                            (conv_overflow | conv_underflow);
      err_set[ADM_E_SAT] = en_r.modulator_stuck_enable & mod_bit_valid &
                           (mod_bit == last_bit_r) &
                           (run_r == ADM_STUCK_RUN - 5'h01);
      err_set[ADM_E_PHI] = en_r.pos_input_high_enable & s_phi;
      err_set[ADM_E_PLO] = en_r.pos_input_low_enable & s_plo;
      err_set[ADM_E_NHI] = en_r.neg_input_high_enable & s_nhi;
      err_set[ADM_E_NLO] = en_r.neg_input_low_enable & s_nlo;
      // Selftest forces the trip as the monitor then sees ground
      err_set[ADM_E_ADR] = en_r.analog_rail_droop_enable &
                           (s_adr | en_r.analog_droop_selftest);
      err_set[ADM_E_DDR] = en_r.digital_rail_droop_enable &
                           (s_ddr | en_r.digital_droop_selftest);
      err_set[ADM_E_CAP] = (en_r.decoupling_check_select == ADM_CAP_ANALOG ||
                            en_r.decoupling_check_select == ADM_CAP_DIGITAL) &&
                           (s_cap || en_r.decoupling_check_selftest);
      err_set[ADM_E_SCK] = en_r.serial_pulse_count_enable & frame_end & bad_count;
   end

   // Clear on the completing edge of an error-register read
   assign err_clr = (apb_done && !pwrite) ? rd_snap_r : '0;

   // One latch per flag
   for (genvar i = 0; i < ADM_ERR_W; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            err_r[i] <= 1'b0;
         end else begin
            err_r[i] <= err_set[i] | (err_r[i] & ~err_clr[i]);
         end
      end
   end

   // Summary bit follows the latched flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         summary_r <= 1'b0;
      end else begin
         summary_r <= |err_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ovf_conv;
      conv_done && conv_overflow;
   endsequence

   chk_clamp_high_result: assert property (s_ovf_conv |=> conv_result == '1)
      else $error("overflow result not clamped high");
   chk_conv_flag_moment: assert property (
      s_ovf_conv and en_r.filter_range_fault_enable
      |=> err_r[ADM_E_CONV] && conv_result_valid)
      else $error("conversion flag not set with data");
   chk_stuck_bitstream: assert property (
      mod_bit_valid && mod_bit == last_bit_r && run_r == 5'h13 && en_r.modulator_stuck_enable
      |=> err_r[ADM_E_SAT])
      else $error("saturation not flagged at twenty");
   chk_offset_hold_bad: assert property (
      cal_done && !cal_is_gain && !offset_ok |=> $stable(offset_coeff))
      else $error("offset loaded out of window");
   chk_gain_hold_ovf: assert property (
      cal_done && cal_is_gain && cal_overflow |=> $stable(gain_coeff))
      else $error("gain loaded on overflow");
   chk_flag_needs_enable: assert property (
      !en_r.calibration_fault_enable && !err_r[ADM_E_CAL] |=> !err_r[ADM_E_CAL])
      else $error("calibration flag set while disabled");
   chk_droop_selftest_trip: assert property (
      en_r.analog_rail_droop_enable && en_r.analog_droop_selftest |=> err_r[ADM_E_ADR])
      else $error("droop selftest did not trip");
   chk_tally_step_131: assert property (
      en_r.osc_tally_enable && presc_r == 8'h82 |=> tally_r == $past(tally_r) + 1'b1)
      else $error("tally step wrong");
   chk_write_abort_bad: assert property (
      frame_end && s_wr && en_r.serial_pulse_count_enable && bad_count
      |=> spi_write_abort && !spi_write_commit)
      else $error("bad write not aborted");
   chk_summary_follows: assert property (err_r != '0 |=> summary_r)
      else $error("summary bit missing");

endmodule // adm_monitor

//--- tb/adm_spi_host.sv
// Serial host stand-in: frames each transfer with its select and clocks it.
// Assumes the bench calls frame(); the clock stands low outside frames.
module adm_spi_host (
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic spi_is_write
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      spi_is_write = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // One framed transfer, any pulse count, 160 ns period
   task automatic frame(input logic wr, input int pulses);
      cs_n <= 1'b0;
      spi_is_write <= wr;
      #80;
      repeat (pulses) begin
         sclk <= 1'b1;
         #80;
         sclk <= 1'b0;
         #80;
      end
      cs_n <= 1'b1;
      #160;
      // Direction released: inverse so a stale level cannot pass
      spi_is_write <= ~wr;
      #400;
   endtask

endmodule // adm_spi_host

//--- tb/tb_adm_monitor.sv
// Bench for the diagnostic monitor: registers, flags, calibration guard,
// serial pulse counting and clock tally.
// Assumes adm_pkg, adm_monitor and adm_spi_host compile first.
module tb_adm_monitor
   import adm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Design pins
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic conv_done, conv_overflow, conv_underflow, conv_result_valid;
   logic [ADM_DATA_W-1:0] conv_raw, conv_result, cal_coeff, offset_coeff, gain_coeff;
   logic mod_bit_valid, mod_bit, cal_done, cal_is_gain, cal_overflow;
   logic pos_input_high, pos_input_low, neg_input_high, neg_input_low;
   logic analog_rail_low, digital_rail_low, decoupling_falling;
   logic analog_droop_gnd, digital_droop_gnd, analog_ldo_off, digital_ldo_off;
   logic decoupling_disconnect, sclk, cs_n, spi_is_write, spi_write_commit, spi_write_abort;
   // Bookkeeping
   int bad_count, samples_checked, cycles, n_commit, n_abort;
   logic [31:0] rd, t1, t2, x;
   logic err;

   // Row: enables, {overflow,underflow}, cap comparator, test pins, flags
   typedef struct packed {
      logic [15:0] en;
      logic [1:0] ou;
      logic fall;
      logic [4:0] outs;
      logic [10:0] flags;
   } adm_row_s;
   adm_row_s r;
   localparam adm_row_s ROWS [10] = '{
      '{16'h0002, 2'h2, 1'b0, 5'h00, 11'h002},
      '{16'h0002, 2'h1, 1'b0, 5'h00, 11'h002},
      '{16'h0002, 2'h0, 1'b0, 5'h00, 11'h000},
      '{16'h0000, 2'h2, 1'b0, 5'h00, 11'h000},
      '{16'h0280, 2'h0, 1'b0, 5'h10, 11'h080},
      '{16'h0500, 2'h0, 1'b0, 5'h08, 11'h100},
      '{16'h0800, 2'h0, 1'b1, 5'h04, 11'h200},
      '{16'h1000, 2'h0, 1'b0, 5'h02, 11'h000},
      '{16'h1800, 2'h0, 1'b1, 5'h00, 11'h000},
      '{16'h2800, 2'h0, 1'b0, 5'h05, 11'h200}};
   // Comparator pin patterns, digital rail at the top
   localparam logic [5:0] MASKS [2] = '{6'h25, 6'h1A};

   adm_monitor i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_done(conv_done), .conv_overflow(conv_overflow), .conv_underflow(conv_underflow),
      .conv_raw(conv_raw), .conv_result(conv_result), .conv_result_valid(conv_result_valid),
      .mod_bit_valid(mod_bit_valid), .mod_bit(mod_bit), .cal_done(cal_done),
      .cal_is_gain(cal_is_gain), .cal_overflow(cal_overflow), .cal_coeff(cal_coeff),
      .offset_coeff(offset_coeff), .gain_coeff(gain_coeff), .pos_input_high(pos_input_high),
      .pos_input_low(pos_input_low), .neg_input_high(neg_input_high),
      .neg_input_low(neg_input_low), .analog_rail_low(analog_rail_low),
      .digital_rail_low(digital_rail_low), .decoupling_falling(decoupling_falling),
      .analog_droop_gnd(analog_droop_gnd), .digital_droop_gnd(digital_droop_gnd),
      .analog_ldo_off(analog_ldo_off), .digital_ldo_off(digital_ldo_off),
      .decoupling_disconnect(decoupling_disconnect), .sclk(sclk), .cs_n(cs_n),
      .spi_is_write(spi_is_write), .spi_write_commit(spi_write_commit),
      .spi_write_abort(spi_write_abort)
   );
   adm_spi_host i_host (.sclk(sclk), .cs_n(cs_n), .spi_is_write(spi_is_write));

   ////////////////////////////////////////////////////////////
   // Clock; commit and abort pulses counted; hang cut short
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (spi_write_commit === 1'b1) n_commit++;
      if (spi_write_abort === 1'b1) n_abort++;
      if (cycles == 50000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {24'h00_0000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register read and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // Run of equal modulator bits
   task automatic mod_run(input logic b, input int n);
      repeat (n) begin
         @(posedge pclk);
         mod_bit_valid <= 1'b1;
         mod_bit <= b;
      end
      @(posedge pclk);
      mod_bit_valid <= 1'b0;
   endtask

   // One calibration result, then a settle edge
   task automatic cal(input logic g, input logic ov, input logic [23:0] c);
      @(posedge pclk);
      {cal_done, cal_is_gain, cal_overflow, cal_coeff} <= {1'b1, g, ov, c};
      @(posedge pclk);
      cal_done <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {conv_done, conv_overflow, conv_underflow, mod_bit_valid, mod_bit} = '0;
      {cal_done, cal_is_gain, cal_overflow, cal_coeff} = '0;
      {pos_input_high, pos_input_low, neg_input_high, neg_input_low} = '0;
      {analog_rail_low, digital_rail_low, decoupling_falling} = '0;
      conv_raw = 24'h5A_5A5A;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk(ADM_OFS_ENABLE, 32'h0000_0000);
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_7FFF);
      rchk(ADM_OFS_ENABLE, 32'h0000_7FFF);
      apb(1'b1, 8'h1C, 32'h0000_FFFF);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_0000);
      rchk(ADM_OFS_ERROR, 32'h0000_0180);
      $display("Test registers done");
      // Table rows: enables, filter event, test pins, flags
      foreach (ROWS[i]) begin
         r = ROWS[i];
         decoupling_falling <= r.fall;
         apb(1'b1, ADM_OFS_ENABLE, {16'h0000, r.en});
         @(posedge pclk);
         {conv_done, conv_overflow, conv_underflow} <= {1'b1, r.ou};
         @(posedge pclk);
         conv_done <= 1'b0;
         repeat (5) @(posedge pclk);
         x = r.ou[1] ? 32'h00FF_FFFF : (r.ou[0] ? 32'h0000_0000 : 32'h005A_5A5A);
         chk({8'h00, conv_result}, x);
         rchk(ADM_OFS_DATA, x);
         chk({27'h0, analog_droop_gnd, digital_droop_gnd, analog_ldo_off, digital_ldo_off,
            decoupling_disconnect}, {27'h0, r.outs});
         rchk(ADM_OFS_ERROR, {21'h0, r.flags});
         apb(1'b1, ADM_OFS_ENABLE, 32'h0000_0000);
         apb(1'b0, ADM_OFS_ERROR, 32'h0000_0000);
         rchk(ADM_OFS_ERROR, 32'h0000_0000);
      end
      $display("Test table done");
      // Runs of 19 are not saturation, 20 is
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_0004);
      mod_run(1'b1, 19);
      mod_run(1'b0, 19);
      rchk(ADM_OFS_ERROR, 32'h0000_0000);
      mod_run(1'b1, 20);
      rchk(ADM_OFS_ERROR, 32'h0000_0004);
      // Offset window edges and gain overflow
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_0001);
      cal(1'b0, 1'b0, 24'h07_FFFF);
      chk({8'h00, offset_coeff}, 32'h0007_FFFF);
      cal(1'b0, 1'b0, 24'h07_FFFE);
      chk({8'h00, offset_coeff}, 32'h0007_FFFF);
      rchk(ADM_OFS_STATUS, 32'h0000_0001);
      rchk(ADM_OFS_ERROR, 32'h0000_0001);
      cal(1'b0, 1'b0, 24'hF8_0001);
      cal(1'b0, 1'b0, 24'hF8_0000);
      rchk(ADM_OFS_OFFSET, 32'h00F8_0000);
      rchk(ADM_OFS_ERROR, 32'h0000_0001);
      cal(1'b1, 1'b0, 24'h12_3456);
      cal(1'b1, 1'b1, 24'h65_4321);
      chk({8'h00, gain_coeff}, 32'h0012_3456);
      rchk(ADM_OFS_ERROR, 32'h0000_0001);
      $display("Test converter done");
      // Input and rail comparators: held, then released
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_01F8);
      apb(1'b0, ADM_OFS_ERROR, 32'h0000_0000);
      foreach (MASKS[i]) begin
         {digital_rail_low, analog_rail_low, neg_input_low, neg_input_high, pos_input_low,
            pos_input_high} <= MASKS[i];
         repeat (5) @(posedge pclk);
         rchk(ADM_OFS_ERROR, {23'h0, MASKS[i], 3'h0});
         repeat (5) @(posedge pclk);
         rchk(ADM_OFS_ERROR, {23'h0, MASKS[i], 3'h0});
         {digital_rail_low, analog_rail_low, neg_input_low, neg_input_high, pos_input_low,
            pos_input_high} <= 6'h00;
         repeat (5) @(posedge pclk);
         rchk(ADM_OFS_ERROR, {23'h0, MASKS[i], 3'h0});
         rchk(ADM_OFS_ERROR, 32'h0000_0000);
      end
      $display("Test comparators done");
      // Serial pulse counts; counting off lets a short write through
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_8000);
      i_host.frame(1'b1, 16);
      i_host.frame(1'b1, 0);
      rchk(ADM_OFS_ERROR, 32'h0000_0000);
      i_host.frame(1'b1, 7);
      rchk(ADM_OFS_ERROR, 32'h0000_0400);
      i_host.frame(1'b0, 9);
      rchk(ADM_OFS_ERROR, 32'h0000_0400);
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_0000);
      i_host.frame(1'b1, 7);
      chk(n_commit, 32'h0000_0003);
      chk(n_abort, 32'h0000_0001);
      $display("Test serial done");
      // Tally over 260 steps, so it wraps; four reads each end
      apb(1'b1, ADM_OFS_ENABLE, 32'h0000_4000);
      repeat (4) apb(1'b0, ADM_OFS_TALLY, 32'h0000_0000);
      t1 = rd;
      repeat (131 * 260 - 4) @(posedge pclk);
      apb(1'b0, ADM_OFS_TALLY, 32'h0000_0000);
      t2 = rd;
      repeat (3) apb(1'b0, ADM_OFS_TALLY, 32'h0000_0000);
      chk((t2 - t1) & 32'h0000_00FF, 32'h0000_0004);
      $display("Test tally done");
      // Reset in mid-run clears tally and enables
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(ADM_OFS_TALLY, 32'h0000_0000);
      rchk(ADM_OFS_ENABLE, 32'h0000_0000);
      rchk(ADM_OFS_ERROR, 32'h0000_0000);
      $display("Test reset done");
      tally_and_finish();
   end

endmodule // tb_adm_monitor
